// ---- fcp_pkg.sv ----
package fcp_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GROUP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_FRESET = 8'h14;
    // control field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_OUT_EN = 2;
    localparam int CTRL_IN_EN = 3;
    localparam int CTRL_PFS_LSB = 4;
    localparam logic [5:0] CTRL_RESET = 6'h04;
    localparam logic [7:0] GROUP_RESET = 8'h00;
    // fault code selection values
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_ALWAYS = 2'h1;
    localparam logic [1:0] SEL_FAULT_ONLY = 2'h2;
    // interrupt status bits
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_OUT_LOSS = 1;
    localparam int IRQ_IN_LOSS = 2;
    localparam int IRQ_DECEL = 3;
    localparam int IRQ_SHUTOFF = 4;
    localparam int NIRQ = 5;
    // external trip inputs, lowest index wins when several arrive together
    localparam int NTRIP = 16;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_OTHER = 4'hF;
    localparam logic [3:0] TRIP_CODE [NTRIP] = '{
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
        4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hE, 4'hF};
    // input phase loss persistence
    localparam int CLK_HZ = 100_000_000;
    localparam int IN_LOSS_TIME_MS = 1000;
    localparam int IN_LOSS_CYCLES = IN_LOSS_TIME_MS * (CLK_HZ / 1000);
    localparam int PERSIST_W = 27;
    typedef enum logic [0:0] {
        FCP_IDLE = 1'b0,
        FCP_TRIPPED = 1'b1
    } fcp_state_t;
endpackage

// ---- fcp_persist.sv ----
`timescale 1ns/1ns
module fcp_persist import fcp_pkg::*; #(
    parameter logic [PERSIST_W-1:0] LIMIT = PERSIST_W'(IN_LOSS_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cond,
    output logic done
);
    logic [PERSIST_W-1:0] count;

    // any gap in the condition restarts the wait
    always_ff @(posedge aclk) begin
        if (!aresetn || !cond) begin
            count <= '0;
        end else if (count != LIMIT) begin
            count <= count + PERSIST_W'(1);
        end
    end

    assign done = cond && (count == LIMIT);
endmodule

// ---- fcp_code_enc.sv ----
`timescale 1ns/1ns
module fcp_code_enc import fcp_pkg::*; (
    input wire logic [NTRIP-1:0] trips,
    input wire logic phase_trip,
    output logic any,
    output logic [3:0] code
);
    always_comb begin
        any = phase_trip || (|trips);
        code = phase_trip ? CODE_OTHER : CODE_NONE;
        for (int i = NTRIP - 1; i >= 0; i--) begin
            if (trips[i]) begin
                code = TRIP_CODE[i];
            end
        end
    end
endmodule

// ---- fcp_top.sv ----
`timescale 1ns/1ns
// Behaviour
// - code select 0..2, default 0 disables
// - select 1 or 2 drives code
// - select 2: code only during fault
// - code bit 1 turns transistor on
// - terminal order and codes 0 to 7
// - codes 8 to F for remaining trips
// - fault code overrides terminal functions
// - output loss protection default on, 0 off
// - lost output phase trips and stops
// - input loss trips after 1 s
// - power fail stop set: decelerate instead
// - first two phases lost: shut off
// - settings writable only when group zero
module fcp_top import fcp_pkg::*; #(
    parameter logic [PERSIST_W-1:0] IN_LOSS_LIMIT = PERSIST_W'(IN_LOSS_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NTRIP-1:0] trip_in,
    input wire logic [2:0] out_phase_lost,
    input wire logic [2:0] in_phase_lost,
    input wire logic fault_reset,
    input wire logic [3:0] out_terminal_func_sel,
    output logic code_bit3_terminal,
    output logic code_bit2_terminal,
    output logic code_bit1_terminal,
    output logic code_bit0_terminal,
    output logic inverter_stop,
    output logic power_fail_decel,
    output logic irq
);
    logic [1:0] fault_code_out_sel;
    logic out_phase_loss_en;
    logic in_phase_loss_en;
    logic [1:0] power_fail_stop_sel;
    logic [7:0] user_group_read_sel;
    logic [NIRQ-1:0] irq_stat;
    logic [NIRQ-1:0] irq_mask;
    fcp_state_t state;
    logic [3:0] fault_code;
    logic [3:0] term;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic sw_reset;
    logic output_phase_loss_trip;
    logic input_phase_loss_trip;
    logic in_first_two_lost;
    logic in_cond;
    logic in_done;
    logic trip_any;
    logic [3:0] trip_code;
    logic reset_req;
    logic [NIRQ-1:0] irq_event;
    logic [31:0] next_rdata;
    logic next_rok;

    // ---------------- AXI4-Lite write path ----------------
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:2] <= ADDR_FRESET[7:2] && aw_addr[7:2] != ADDR_STATUS[7:2]) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only 0..2 accepted, others leave setting unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_code_out_sel <= CTRL_RESET[CTRL_SEL_LSB +: 2];
            out_phase_loss_en <= CTRL_RESET[CTRL_OUT_EN];
            in_phase_loss_en <= CTRL_RESET[CTRL_IN_EN];
            power_fail_stop_sel <= CTRL_RESET[CTRL_PFS_LSB +: 2];
        end else if (wr_fire && w_strb[0] && aw_addr == ADDR_CTRL && user_group_read_sel == 8'h00) begin
            if (w_data[CTRL_SEL_LSB +: 2] != 2'h3) begin
                fault_code_out_sel <= w_data[CTRL_SEL_LSB +: 2];
            end
            out_phase_loss_en <= w_data[CTRL_OUT_EN];
            in_phase_loss_en <= w_data[CTRL_IN_EN];
            power_fail_stop_sel <= w_data[CTRL_PFS_LSB +: 2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            user_group_read_sel <= GROUP_RESET;
        end else if (wr_fire && w_strb[0] && aw_addr == ADDR_GROUP) begin
            user_group_read_sel <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (wr_fire && w_strb[0] && aw_addr == ADDR_IRQ_MASK) begin
            irq_mask <= w_data[NIRQ-1:0];
        end
    end

    assign sw_reset = wr_fire && w_strb[0] && aw_addr == ADDR_FRESET && w_data[0];

    // new events win over a same-cycle write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else if (wr_fire && w_strb[0] && aw_addr == ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~w_data[NIRQ-1:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ---------------- AXI4-Lite read path ----------------
    assign s_axi_arready = !s_axi_rvalid;
    // unmapped reads answer slverr with zero data

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rok = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CTRL: begin
                next_rdata[CTRL_SEL_LSB +: 2] = fault_code_out_sel;
                next_rdata[CTRL_OUT_EN] = out_phase_loss_en;
                next_rdata[CTRL_IN_EN] = in_phase_loss_en;
                next_rdata[CTRL_PFS_LSB +: 2] = power_fail_stop_sel;
            end
            ADDR_GROUP: next_rdata[7:0] = user_group_read_sel;
            ADDR_STATUS: next_rdata[7:0] = {power_fail_decel, inverter_stop, in_cond, state, fault_code};
            ADDR_IRQ_STAT: next_rdata[NIRQ-1:0] = irq_stat;
            ADDR_IRQ_MASK: next_rdata[NIRQ-1:0] = irq_mask;
            ADDR_FRESET: next_rdata = 32'h0000_0000;
            default: next_rok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- phase loss detection ----------------
    // trip gated by enable
    assign output_phase_loss_trip = out_phase_loss_en && (|out_phase_lost);
    // first two phases together shut off without trip
    assign in_first_two_lost = in_phase_lost[0] && in_phase_lost[1];
    // power fail stop takes over from the trip
    assign power_fail_decel = in_phase_loss_en && power_fail_stop_sel != 2'h0 && (|in_phase_lost);
    assign in_cond = in_phase_loss_en && power_fail_stop_sel == 2'h0 && (|in_phase_lost) && !in_first_two_lost;

    // default limit is 1 s of aclk; benches shrink it
    // persistence before tripping
    fcp_persist #(
        .LIMIT(IN_LOSS_LIMIT)
    ) u_in_persist (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond(in_cond),
        .done(in_done)
    );
    assign input_phase_loss_trip = in_done;

    // phase loss trips report code F; an external trip in the same cycle wins with its own code
    fcp_code_enc u_enc (
        .trips(trip_in),
        .phase_trip(output_phase_loss_trip || input_phase_loss_trip),
        .any(trip_any),
        .code(trip_code)
    );

    // stop output on any trip or shutoff
    assign inverter_stop = (state == FCP_TRIPPED) || in_first_two_lost;
    assign reset_req = fault_reset || sw_reset;
    assign irq_event = {in_first_two_lost, power_fail_decel, input_phase_loss_trip,
                        output_phase_loss_trip, (state == FCP_IDLE) && trip_any};

    // ---------------- fault latch ----------------
    // first code held until reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FCP_IDLE;
            fault_code <= CODE_NONE;
        end else begin
            unique case (state)
                FCP_IDLE: begin
                    if (trip_any) begin
                        state <= FCP_TRIPPED;
                        fault_code <= trip_code;
                    end
                end
                FCP_TRIPPED: begin
                    if (reset_req) begin
                        state <= FCP_IDLE;
                        fault_code <= CODE_NONE;
                    end
                end
            endcase
        end
    end

    // ---------------- terminal drive ----------------
    // nonzero select drives code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term <= 4'h0;
        end else if (fault_code_out_sel == SEL_OFF) begin
            term <= out_terminal_func_sel;
        end else if (state == FCP_TRIPPED) begin
            term <= fault_code;
        end else if (fault_code_out_sel == SEL_FAULT_ONLY) begin
            term <= out_terminal_func_sel;
        end else begin
            term <= CODE_NONE;
        end
    end

    // a 1 switches the transistor on
    assign code_bit3_terminal = term[3];
    assign code_bit2_terminal = term[2];
    assign code_bit1_terminal = term[1];
    assign code_bit0_terminal = term[0];

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_sel_range: assert property (fault_code_out_sel != 2'h3)
        else $error("code select out of range");
    chk_code_drive: assert property ((state == FCP_TRIPPED && fault_code_out_sel != SEL_OFF) |=>
        ({code_bit3_terminal, code_bit2_terminal, code_bit1_terminal, code_bit0_terminal} == $past(fault_code)))
        else $error("fault code not on terminals");
    chk_fault_only: assert property ((state == FCP_IDLE && fault_code_out_sel == SEL_FAULT_ONLY) |=>
        (term == $past(out_terminal_func_sel)))
        else $error("normal functions not passed");
    chk_select_off: assert property ((fault_code_out_sel == SEL_OFF) |=> (term == $past(out_terminal_func_sel)))
        else $error("disabled code output overrides");
    chk_code_override: assert property ((state == FCP_TRIPPED && fault_code_out_sel == SEL_FAULT_ONLY) |=>
        (term == $past(fault_code)))
        else $error("code not overriding functions");
    chk_idle_zero: assert property ((state == FCP_IDLE && fault_code_out_sel == SEL_ALWAYS) |=> (term == CODE_NONE))
        else $error("no-fault code not zero");
    chk_out_loss: assert property ((state == FCP_IDLE && out_phase_loss_en && (|out_phase_lost)
        && !(|trip_in)) |=> (state == FCP_TRIPPED && fault_code == CODE_OTHER && inverter_stop))
        else $error("output phase loss missed");
    chk_out_disable: assert property (!out_phase_loss_en |-> !output_phase_loss_trip)
        else $error("disabled output loss tripped");
    chk_in_decel: assert property ((in_phase_loss_en && power_fail_stop_sel != 2'h0 && (|in_phase_lost)) |->
        (power_fail_decel && !input_phase_loss_trip))
        else $error("decel not taken");
    chk_two_lost: assert property (in_first_two_lost |-> (inverter_stop && !input_phase_loss_trip))
        else $error("first two phases not shut off");
    chk_in_wait: assert property ($rose(input_phase_loss_trip) |-> $past(in_cond, 3))
        else $error("input loss tripped early");
    chk_locked_write: assert property ((wr_fire && aw_addr == ADDR_CTRL && user_group_read_sel != 8'h00) |=>
        $stable({fault_code_out_sel, out_phase_loss_en, in_phase_loss_en, power_fail_stop_sel}))
        else $error("locked setting changed");
    chk_code_hold: assert property ((state == FCP_TRIPPED && !reset_req) |=>
        (state == FCP_TRIPPED && $stable(fault_code)))
        else $error("fault code not held");
    chk_code_bits: assert property ((state == FCP_TRIPPED && fault_code_out_sel == SEL_ALWAYS) |=>
        (code_bit3_terminal == $past(fault_code[3]) && code_bit0_terminal == $past(fault_code[0])))
        else $error("terminal bit order wrong");
    chk_ext_code: assert property ((state == FCP_IDLE && trip_in[0]) |=> (fault_code == TRIP_CODE[0]))
        else $error("trip code wrong");

    cov_trip_sel2: cover property (state == FCP_TRIPPED && fault_code_out_sel == SEL_FAULT_ONLY);
    cov_out_loss: cover property (state == FCP_IDLE && output_phase_loss_trip);
    cov_in_loss: cover property ($rose(input_phase_loss_trip));
    cov_decel: cover property (power_fail_decel);
    cov_reset: cover property (state == FCP_TRIPPED && reset_req);
endmodule

// ---- fcp_plc.sv ----
`timescale 1ns/1ns
module fcp_plc (
    input wire logic bit3,
    input wire logic bit2,
    input wire logic bit1,
    input wire logic bit0,
    output logic [3:0] code
);
    // transistor on reads one, msb first
    assign code = {bit3, bit2, bit1, bit0};
endmodule

// ---- fcp_top_tb.sv ----
`timescale 1ns/1ns
module fcp_top_tb;
    import fcp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [NTRIP-1:0] trip = '0;
    logic [2:0] out_lost = 3'h0, in_lost = 3'h0;
    logic frst = 1'b0;
    logic [3:0] fsel = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, t3, t2, t1, t0, inv_stop, pf_decel, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [3:0] plc_code;
    int failures = 0, samples_checked = 0, cyc = 0, m_sel = 0, m_ctrl = 4, m_trip = 0, i;
    logic [3:0] m_code;
    int tbl [16] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 14, 15};

    fcp_top #(.IN_LOSS_LIMIT(PERSIST_W'(20))) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trip_in(trip), .out_phase_lost(out_lost), .in_phase_lost(in_lost), .fault_reset(frst),
        .out_terminal_func_sel(fsel), .code_bit3_terminal(t3), .code_bit2_terminal(t2),
        .code_bit1_terminal(t1), .code_bit0_terminal(t0), .inverter_stop(inv_stop),
        .power_fail_decel(pf_decel), .irq(irq));
    fcp_plc PLC (.bit3(t3), .bit2(t2), .bit1(t1), .bit0(t0), .code(plc_code));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("BAD %0t run did not complete", $time);
            end_sim();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic chk_pin(input logic [3:0] g, input logic [3:0] e, input string m);
        chk_reg({28'h0, g}, {28'h0, e}, m);
    endtask

    // both channels offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic set_ctrl(input int s, input int o, input int ie, input int p);
        m_ctrl = s | (o << 2) | (ie << 3) | (p << 4);
        m_sel = s;
        axw(ADDR_CTRL, 32'(m_ctrl));
    endtask

    function automatic logic [3:0] exp_term();
        if (m_sel == 0) return fsel;
        if (m_trip != 0) return m_code;
        return (m_sel == 1) ? 4'h0 : fsel;
    endfunction

    task automatic clr();
        frst <= 1'b1;
        tick(1);
        frst <= 1'b0;
        m_trip = 0;
        tick(2);
    endtask

    task automatic fault(input logic [3:0] c);
        tick(3);
        m_trip = 1;
        m_code = c;
        chk_pin(plc_code, exp_term(), "code on terminals");
    endtask

    initial begin
        void'($urandom(54));
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        axr(ADDR_CTRL);
        chk_reg(d, 32'h4, "ctrl after reset");
        axr(ADDR_GROUP);
        chk_reg(d, 32'h0, "group after reset");
        axr(8'h40);
        chk_pin({2'b00, r}, 4'h2, "unmapped read");
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            set_ctrl((i % 2) ? 1 : 2, 1, 0, 0);
            fsel <= 4'($urandom);
            tick(2);
            chk_pin(plc_code, exp_term(), "normal state");
            trip <= 16'h1 << i;
            fault(4'(tbl[i]));
            trip <= '0;
            fsel <= 4'($urandom);
            tick(3);
            chk_pin(plc_code, exp_term(), "code held");
            clr();
            chk_pin(plc_code, exp_term(), "after fault reset");
        end
        $display("test codes done");
        axw(ADDR_IRQ_MASK, 32'h1);
        chk_pin({3'b000, irq}, 4'h1, "irq raised");
        axw(ADDR_IRQ_STAT, 32'h1);
        chk_pin({3'b000, irq}, 4'h0, "irq cleared");
        axw(ADDR_IRQ_MASK, 32'h0);
        set_ctrl(0, 1, 0, 0);
        trip <= 16'h0010;
        fault(4'h5);
        trip <= '0;
        clr();
        $display("test irq and sel zero done");
        set_ctrl(1, 1, 0, 0);
        out_lost <= 3'b010;
        fault(CODE_OTHER);
        chk_pin({3'b000, inv_stop}, 4'h1, "stopped on out loss");
        out_lost <= 3'b000;
        clr();
        set_ctrl(1, 0, 0, 0);
        out_lost <= 3'b001;
        tick(5);
        chk_pin(plc_code, exp_term(), "out loss disabled");
        chk_pin({3'b000, inv_stop}, 4'h0, "no stop when disabled");
        out_lost <= 3'b000;
        $display("test out loss done");
        set_ctrl(1, 1, 1, 0);
        in_lost <= 3'b100;
        tick(14);
        axr(ADDR_STATUS);
        chk_pin({3'b000, d[4]}, 4'h0, "in loss not yet");
        chk_pin({3'b000, d[5]}, 4'h1, "in loss pending");
        tick(8);
        fault(CODE_OTHER);
        in_lost <= 3'b000;
        clr();
        set_ctrl(1, 1, 1, 2);
        in_lost <= 3'b100;
        tick(30);
        chk_pin({3'b000, pf_decel}, 4'h1, "decel instead");
        chk_pin(plc_code, exp_term(), "no trip with decel");
        set_ctrl(1, 1, 1, 0);
        in_lost <= 3'b011;
        tick(30);
        chk_pin({3'b000, inv_stop}, 4'h1, "shut off");
        chk_pin(plc_code, exp_term(), "no trip on shut off");
        in_lost <= 3'b000;
        $display("test in loss done");
        axw(ADDR_GROUP, 32'h1);
        axw(ADDR_CTRL, 32'h2);
        axr(ADDR_CTRL);
        chk_reg(d, 32'(m_ctrl), "ctrl locked");
        axw(ADDR_GROUP, 32'h0);
        set_ctrl(2, 1, 0, 0);
        axr(ADDR_CTRL);
        chk_reg(d, 32'(m_ctrl), "ctrl unlocked");
        axw(ADDR_CTRL, 32'h7);
        axr(ADDR_CTRL);
        chk_reg(d, 32'h6, "sel 3 refused");
        axw(ADDR_STATUS, 32'h0);
        chk_pin({2'b00, r}, 4'h2, "status write refused");
        $display("test lock done");
        end_sim();
    end
endmodule
